// ==== ssg_defs.svh ====
// Offsets, field positions, reset values and timing figures of the feedback strobe generator.
`ifndef SSG_DEFS_SVH
`define SSG_DEFS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define SSG_CTRL_OFS 12'h000
`define SSG_STAT_OFS 12'h004
`define SSG_CTRL_RESET 32'h0000_001c

// ----------------------------------------------------------------------------
// Control word fields
// ----------------------------------------------------------------------------
`define SSG_CTRL_SEL_LSB 0
`define SSG_CTRL_SRC_LSB 2
`define SSG_CTRL_PM_LSB 5

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SSG_CLK_MHZ 50
`define SSG_FAIL_PERIOD_US 6500
`define SSG_OVF_PULSE_US 100
`define SSG_BLANK_NS 2000
`define SSG_PRESC_HALF 18'h00200

`endif

// ==== ssg_pkg.sv ====
// Types shared by the feedback strobe generator modules.
package ssg_pkg;

    typedef enum logic [1:0] {
        ssg_mode_normal = 2'b00,
        ssg_mode_fail = 2'b01,
        ssg_mode_sleep = 2'b10
    } ssg_mode_e;

    typedef enum logic [2:0] {
        ssg_src_ch1 = 3'b000,
        ssg_src_ch2 = 3'b001,
        ssg_src_ch3 = 3'b010,
        ssg_src_ch4 = 3'b011,
        ssg_src_ch5 = 3'b100,
        ssg_src_temp = 3'b101,
        ssg_src_supply = 3'b110,
        ssg_src_none = 3'b111
    } ssg_src_e;

    typedef enum logic [1:0] {
        ssg_strb_off = 2'b00,
        ssg_strb_valid = 2'b01,
        ssg_strb_restart = 2'b10,
        ssg_strb_midpoint = 2'b11
    } ssg_strb_e;

    typedef struct packed {
        logic [17:0] cnt;
        logic level;
    } ssg_sq_state_s;

    typedef struct packed {
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
        logic wr_ctrl;
        ssg_strb_e strb_sel;
        ssg_src_e src;
        ssg_src_e src_prev;
        logic [4:0] pm_enable;
        logic [4:0] polarity;
        logic [4:0] fault_lat;
        logic [4:0] en_prev;
        logic on_prev;
        logic [15:0] on_cnt;
        logic [15:0] on_len;
        logic mid_ok;
        logic wait_cycle;
        logic [15:0] blank;
        logic [12:0] ovf_cnt;
        logic strobe_low;
        logic fb_en;
    } ssg_state_s;

endpackage

// ==== ssg_square_wave.sv ====
// Half-period counter that makes the 50% duty strobe square waves.
`timescale 1ns/100ps
module ssg_square_wave (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Control
    input wire logic run,
    input wire logic tick,
    input wire logic [17:0] half_period,
    // Result
    output logic level
);
    ssg_pkg::ssg_sq_state_s s;
    ssg_pkg::ssg_sq_state_s n;

    always_comb begin
        n = s;
        if (!run) begin
            // Idle waves sit high so the open-drain pin is released.
            n.cnt = 18'h00000;
            n.level = 1'b1;
        end else if (tick) begin
            if (s.cnt + 18'h00001 >= half_period) begin
                n.cnt = 18'h00000;
                n.level = ~s.level;
            end else begin
                n.cnt = s.cnt + 18'h00001;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.level <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign level = s.level;
endmodule

// ==== ssg_strobe_gen.sv ====
// Feedback gating, sampling strobe and precision sense control of a five channel switch.
//
// Contract
// RL1: No current feedback during inrush window.
// RL2: PWM channel feeds back only while on.
// RL3: Precision mode flips offset at strobe rise.
// RL4: Controller averages consecutive sample pairs.
// RL5: Precision enable per channel, off in fail.
// RL6: Precision mode halves full scale and limit.
// RL7: Strobe only in Normal mode.
// RL8: Select 00 high, 01 low while valid.
// RL9: Select 10 waits after mux change.
// RL10: Select 11 pulses from midpoint to end.
// RL11: No strobe in inrush or off phase.
// RL12: Blank after mux change and polarity switch.
// RL13: Clock fail with current: 6.5 ms square.
// RL14: Full duty: low, 100 us overflow pulse.
// RL15: No trigger after fault until re-enabled.
// RL16: Voltage source: square at clock/1024.
// RL17: Voltage source, clock fail: 6.5 ms square.
// RL18: Strobe is open drain, low when active.
// RL19: Feedback and strobe only in Normal mode.
// RL20: Three-bit source select routes feedback.
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
`include "ssg_defs.svh"
module ssg_strobe_gen #(
    parameter logic [17:0] FAIL_HALF_CYC = 18'(`SSG_FAIL_PERIOD_US * `SSG_CLK_MHZ / 2),
    parameter logic [12:0] OVF_CYC = 13'(`SSG_OVF_PULSE_US * `SSG_CLK_MHZ),
    parameter logic [15:0] BLANK_CYC = 16'((`SSG_BLANK_NS * `SSG_CLK_MHZ + 999) / 1000)
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Device state
    input wire logic [1:0] device_mode,
    input wire logic pwm_clk_tick,
    input wire logic pwm_cycle_start,
    input wire logic pwm_clock_failed,
    // Per channel state
    input wire logic [4:0] channel_on,
    input wire logic [4:0] channel_enabled,
    input wire logic [4:0] channel_full_duty,
    input wire logic [4:0] inrush_overcurrent_window,
    input wire logic [4:0] output_fault,
    // Feedback control
    output logic feedback_enable,
    output logic [2:0] feedback_source_select,
    output logic [4:0] precision_sense_mode,
    output logic [4:0] sense_polarity,
    output logic [4:0] range_halved,
    // Open-drain sampling strobe
    output logic feedback_sample_strobe_o,
    output logic feedback_sample_strobe_oe
);
    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic is_current(input ssg_pkg::ssg_src_e src);
        return src <= ssg_pkg::ssg_src_ch5;
    endfunction

    function automatic logic addr_phase(input logic sel, input logic [1:0] trans, input logic rdy);
        return sel & trans[1] & rdy;
    endfunction

    ssg_pkg::ssg_state_s s;
    ssg_pkg::ssg_state_s n;

    logic sq_level;
    logic sq_run;
    logic sq_tick;
    logic [17:0] sq_half;

    logic normal;
    logic failm;
    logic cur;
    logic [2:0] ch;
    logic ch_on;
    logic ch_inrush;
    logic ch_fault;
    logic mux_change;
    logic on_rise;
    logic on_fall;
    logic blanking;
    logic valid;
    logic full_low;
    logic at_mid;
    logic want_low;
    logic pol_switch;

    // ------------------------------------------------------------------------
    // Square wave source
    // ------------------------------------------------------------------------
    always_comb begin
        // The fallback timing uses the system clock, since the PWM clock is gone.
        sq_tick = pwm_clock_failed ? 1'b1 : pwm_clk_tick;
        sq_half = pwm_clock_failed ? FAIL_HALF_CYC : `SSG_PRESC_HALF;
        sq_run = (device_mode == ssg_pkg::ssg_mode_normal) && (s.src != ssg_pkg::ssg_src_none)
            && (!is_current(s.src) || (pwm_clock_failed && s.strb_sel != ssg_pkg::ssg_strb_off));
    end

    ssg_square_wave u_sq (
        .mclk(mclk),
        .rst(rst),
        .run(sq_run),
        .tick(sq_tick),
        .half_period(sq_half),
        .level(sq_level)
    );

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        n = s;
        normal = device_mode == ssg_pkg::ssg_mode_normal; // see RL19
        failm = device_mode == ssg_pkg::ssg_mode_fail;
        cur = is_current(s.src); // see RL20
        ch = cur ? s.src : 3'h0;
        ch_on = channel_on[ch];
        ch_inrush = inrush_overcurrent_window[ch];
        ch_fault = s.fault_lat[ch];
        mux_change = s.src != s.src_prev;
        on_rise = ch_on & ~s.on_prev;
        on_fall = ~ch_on & s.on_prev;

        // Bus slave: zero wait states, always OKAY, unmapped reads give zero.
        n.hreadyout = 1'b1;
        n.hresp = 1'b0;
        if (s.wr_ctrl) begin
            n.strb_sel = ssg_pkg::ssg_strb_e'(hwdata[`SSG_CTRL_SEL_LSB +: 2]);
            n.src = ssg_pkg::ssg_src_e'(hwdata[`SSG_CTRL_SRC_LSB +: 3]);
            n.pm_enable = hwdata[`SSG_CTRL_PM_LSB +: 5];
        end
        if (failm) begin
            n.pm_enable = 5'h00; // see RL5
        end
        n.wr_ctrl = addr_phase(hsel, htrans, hready) && hwrite && haddr == `SSG_CTRL_OFS;
        n.hrdata = 32'h0000_0000;
        if (addr_phase(hsel, htrans, hready) && !hwrite) begin
            if (haddr == `SSG_CTRL_OFS) begin
                n.hrdata = {22'h000000, n.pm_enable, n.src, n.strb_sel};
            end else if (haddr == `SSG_STAT_OFS) begin
                n.hrdata = {11'h000, device_mode, pwm_clock_failed, s.strobe_low, s.fb_en,
                            s.fault_lat, s.polarity, s.on_len[15:10]};
            end
        end

        // Faults hold off triggers until the output is enabled again; a new fault wins.
        n.en_prev = channel_enabled;
        n.fault_lat = (s.fault_lat & ~(channel_enabled & ~s.en_prev)) | output_fault; // see RL15

        // On-time measurement for the midpoint trigger.
        n.src_prev = s.src;
        n.on_prev = ch_on;
        if (on_rise) begin
            n.on_cnt = 16'h0000;
        end else if (ch_on && s.on_cnt != 16'hffff) begin
            n.on_cnt = s.on_cnt + 16'h0001;
        end
        if (on_fall) begin
            n.on_len = s.on_cnt;
            n.mid_ok = 1'b1;
        end
        if (mux_change) begin
            n.mid_ok = 1'b0; // see RL10
        end
        at_mid = s.mid_ok && (s.on_cnt >= {1'b0, s.on_len[15:1]});

        // After a source change, the restart setting waits for a new PWM period.
        if (mux_change) begin
            n.wait_cycle = 1'b1; // see RL9
        end else if (pwm_cycle_start) begin
            n.wait_cycle = 1'b0;
        end

        if (pwm_cycle_start) begin
            n.ovf_cnt = OVF_CYC;
        end else if (s.ovf_cnt != 13'h0000) begin
            n.ovf_cnt = s.ovf_cnt - 13'h0001;
        end

        blanking = (s.blank != 16'h0000) || mux_change || on_rise;
        valid = ch_on && !ch_inrush && !ch_fault && !blanking; // see RL11
        full_low = channel_full_duty[ch] && valid && s.ovf_cnt == 13'h0000 && !s.wait_cycle; // see RL14

        // Strobe demand; high-impedance release is the inactive level.
        want_low = 1'b0;
        if (!normal || s.src == ssg_pkg::ssg_src_none) begin
            want_low = 1'b0; // see RL7
        end else if (!cur) begin
            want_low = ~sq_level; // see RL16
        end else if (pwm_clock_failed) begin
            want_low = (s.strb_sel != ssg_pkg::ssg_strb_off) && !sq_level; // see RL13
        end else begin
            case (s.strb_sel)
                ssg_pkg::ssg_strb_off: want_low = 1'b0; // see RL8
                ssg_pkg::ssg_strb_valid: want_low = valid; // see RL8
                ssg_pkg::ssg_strb_restart: begin
                    want_low = channel_full_duty[ch] ? full_low : (valid && !s.wait_cycle); // see RL9
                end
                ssg_pkg::ssg_strb_midpoint: begin
                    want_low = channel_full_duty[ch] ? full_low : (valid && at_mid); // see RL10
                end
                default: want_low = 1'b0;
            endcase
        end
        n.strobe_low = want_low;

        // A rising strobe in precision mode flips the amplifier offset of that channel.
        pol_switch = cur && s.strobe_low && !want_low && s.pm_enable[ch];
        if (pol_switch) begin
            n.polarity[ch] = ~s.polarity[ch]; // see RL3
        end

        if (mux_change || pol_switch || on_rise) begin
            n.blank = BLANK_CYC; // see RL12
        end else if (s.blank != 16'h0000) begin
            n.blank = s.blank - 16'h0001;
        end

        // Current feedback flows only in the on phase and outside the inrush window.
        if (!normal || s.src == ssg_pkg::ssg_src_none) begin
            n.fb_en = 1'b0; // see RL19
        end else if (cur) begin
            n.fb_en = ch_on && !ch_inrush; // see RL1, see RL2
        end else begin
            n.fb_en = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.src <= ssg_pkg::ssg_src_none;
            s.src_prev <= ssg_pkg::ssg_src_none;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign hreadyout = s.hreadyout;
    assign hresp = s.hresp;
    assign hrdata = s.hrdata;
    assign feedback_enable = s.fb_en;
    assign feedback_source_select = s.src;
    assign precision_sense_mode = s.pm_enable;
    assign sense_polarity = s.polarity;
    assign range_halved = s.pm_enable; // see RL6
    assign feedback_sample_strobe_o = 1'b0; // see RL18
    assign feedback_sample_strobe_oe = s.strobe_low; // see RL18

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    property p_inrush_no_feedback; // see RL1
        @(posedge mclk) disable iff (rst)
        normal && cur && ch_inrush |=> !feedback_enable;
    endproperty
    a_inrush_no_feedback: assert property (p_inrush_no_feedback) else $error("feedback during inrush");

    property p_off_no_feedback; // see RL2
        @(posedge mclk) disable iff (rst)
        cur && !ch_on |=> !feedback_enable;
    endproperty
    a_off_no_feedback: assert property (p_off_no_feedback) else $error("feedback during off time");

    property p_polarity_flip; // see RL3
        @(posedge mclk) disable iff (rst)
        cur && s.strobe_low && !want_low && s.pm_enable[ch] |=> sense_polarity != $past(sense_polarity);
    endproperty
    a_polarity_flip: assert property (p_polarity_flip) else $error("offset not flipped on strobe rise");

    property p_fail_no_precision; // see RL5
        @(posedge mclk) disable iff (rst)
        failm |=> precision_sense_mode == 5'h00 && range_halved == 5'h00;
    endproperty
    a_fail_no_precision: assert property (p_fail_no_precision) else $error("precision mode in fail mode");

    property p_strobe_normal_only; // see RL7
        @(posedge mclk) disable iff (rst)
        !normal |=> !feedback_sample_strobe_oe && !feedback_enable;
    endproperty
    a_strobe_normal_only: assert property (p_strobe_normal_only) else $error("strobe outside normal mode");

    property p_select_off; // see RL8
        @(posedge mclk) disable iff (rst)
        cur && !pwm_clock_failed && s.strb_sel == ssg_pkg::ssg_strb_off |=> !feedback_sample_strobe_oe;
    endproperty
    a_select_off: assert property (p_select_off) else $error("strobe active with select off");

    sequence s_blank_hold;
        !feedback_sample_strobe_oe [*8];
    endsequence
    property p_mux_blank; // see RL12
        @(posedge mclk) disable iff (rst)
        mux_change && cur && !pwm_clock_failed |=> s_blank_hold;
    endproperty
    a_mux_blank: assert property (p_mux_blank) else $error("strobe not blanked after mux change");

    property p_inrush_no_strobe; // see RL11
        @(posedge mclk) disable iff (rst)
        cur && !pwm_clock_failed && (ch_inrush || !ch_on) |=> !feedback_sample_strobe_oe;
    endproperty
    a_inrush_no_strobe: assert property (p_inrush_no_strobe) else $error("strobe in inrush or off phase");

    property p_fault_no_trigger; // see RL15
        @(posedge mclk) disable iff (rst)
        cur && !pwm_clock_failed && ch_fault |=> !feedback_sample_strobe_oe;
    endproperty
    a_fault_no_trigger: assert property (p_fault_no_trigger) else $error("trigger after output fault");

    property p_overflow_pulse; // see RL14
        @(posedge mclk) disable iff (rst)
        normal && cur && !pwm_clock_failed && pwm_cycle_start && channel_full_duty[ch]
            && s.strb_sel[1] |=> ##1 !feedback_sample_strobe_oe [*8];
    endproperty
    a_overflow_pulse: assert property (p_overflow_pulse) else $error("no high pulse at overflow");
endmodule

// ==== ssg_mcu_model.sv ====
// Behavioural model of the controller that samples the feedback pin on each strobe.
`timescale 1ns/100ps
module ssg_mcu_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Strobe pin level after the pull-up
    input wire logic strobe_pin,
    // Observed run lengths and completed sample pairs
    output logic [31:0] low_len,
    output logic [31:0] high_len,
    output logic [31:0] pair_count
);
    logic [31:0] run;
    logic prev;
    logic half;

    // Run lengths let the bench judge square waves without trusting any design count.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            run <= 32'h0000_0001;
            prev <= 1'b1;
            half <= 1'b0;
            low_len <= 32'h0;
            high_len <= 32'h0;
            pair_count <= 32'h0;
        end else begin
            prev <= strobe_pin;
            if (strobe_pin == prev) begin
                run <= run + 32'h1;
            end else begin
                run <= 32'h0000_0001;
                if (prev) begin
                    high_len <= run;
                end else begin
                    low_len <= run;
                end
                if (!strobe_pin) begin
                    // Samples taken at falling strobe are averaged two by two to cancel offset.
                    half <= !half;
                    if (half) begin
                        pair_count <= pair_count + 32'h1;
                    end
                end
            end
        end
    end
endmodule

// ==== sense_sync_strobe_gen_test.sv ====
// Self-checking testbench of the feedback strobe generator.
`timescale 1ns/100ps
`include "ssg_defs.svh"
module sense_sync_strobe_gen_test;
    localparam int BLANK = 10;
    localparam int OVF = 16;
    localparam int FAILH = 16;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp;
    logic [31:0] hrdata, rd, low_len, high_len, pair_count;
    logic [1:0] device_mode = 2'b00;
    logic pwm_clk_tick = 1'b0;
    logic pwm_cycle_start = 1'b0;
    logic pwm_clock_failed = 1'b0;
    logic [1:0] on_low = 2'b00;
    logic [2:0] on_noise = 3'b000;
    logic [4:0] channel_enabled = 5'h1f;
    logic [4:0] full_duty = 5'h00;
    logic [4:0] inrush = 5'h00;
    logic [4:0] fault = 5'h00;
    logic feedback_enable, strobe_o, strobe_oe, pol, bad;
    logic [2:0] src_sel;
    logic [4:0] pm_mode, polarity, halved;
    int fail_count = 0;
    int checks = 0;
    int seed = 60;
    int len;
    wire strobe_pin = strobe_oe ? strobe_o : 1'b1;

    always #10 mclk = ~mclk;
    always @(posedge mclk) on_noise <= 3'($random(seed));

    ssg_strobe_gen #(.FAIL_HALF_CYC(18'd16), .OVF_CYC(13'd16), .BLANK_CYC(16'd10)) u_dut (
        .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .device_mode(device_mode), .pwm_clk_tick(pwm_clk_tick),
        .pwm_cycle_start(pwm_cycle_start), .pwm_clock_failed(pwm_clock_failed),
        .channel_on({on_noise, on_low}), .channel_enabled(channel_enabled),
        .channel_full_duty(full_duty), .inrush_overcurrent_window(inrush), .output_fault(fault),
        .feedback_enable(feedback_enable), .feedback_source_select(src_sel),
        .precision_sense_mode(pm_mode), .sense_polarity(polarity), .range_halved(halved),
        .feedback_sample_strobe_o(strobe_o), .feedback_sample_strobe_oe(strobe_oe));

    ssg_mcu_model u_mcu (.mclk(mclk), .rst(rst), .strobe_pin(strobe_pin), .low_len(low_len),
        .high_len(high_len), .pair_count(pair_count));

    // ------------------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------------------
    task automatic final_report;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: output %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: register %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            final_report();
        end
    endtask

    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        r = hrdata;
    endtask

    function automatic logic [31:0] ctrl_word(input logic [1:0] sel, input logic [2:0] src, input logic [4:0] pm);
        return (32'(pm) << `SSG_CTRL_PM_LSB) | (32'(src) << `SSG_CTRL_SRC_LSB) | (32'(sel) << `SSG_CTRL_SEL_LSB);
    endfunction

    task automatic set_ctrl(input logic [1:0] sel, input logic [2:0] src, input logic [4:0] pm);
        bus(`SSG_CTRL_OFS, 1'b1, ctrl_word(sel, src, pm), rd);
        bus(`SSG_CTRL_OFS, 1'b0, 32'h0, rd);
        chk_reg(rd, ctrl_word(sel, src, pm));
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic cycle_start;
        pwm_cycle_start <= 1'b1;
        cyc(1);
        pwm_cycle_start <= 1'b0;
    endtask

    // The midpoint setting needs a previous pulse of the same length to place its strobe.
    task automatic mid_pulse(input int l, input logic check);
        on_low[1] <= 1'b1;
        cyc(l / 2 - 4);
        if (check) chk_out(strobe_pin, 1'b1);
        cyc(8);
        if (check) chk_out(strobe_pin, 1'b0);
        cyc(l - l / 2 - 4);
        on_low[1] <= 1'b0;
        cyc(12);
    endtask

    initial begin
        cyc(20000);
        fail_count++;
        final_report();
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        cyc(10);
        rst <= 1'b0;
        cyc(1);
        bus(`SSG_CTRL_OFS, 1'b0, 32'h0, rd);
        chk_reg(rd, `SSG_CTRL_RESET);
        chk_out(hresp, 1'b0);
        chk_out(src_sel, 3'b111);
        bus(12'h008, 1'b1, 32'hffff_ffff, rd);
        bus(12'h008, 1'b0, 32'h0, rd);
        chk_reg(rd, 32'h0);
        set_ctrl(2'b01, 3'b000, 5'b00001);
        chk_out(pm_mode, 5'b00001);
        chk_out(halved, 5'b00001);
        chk_out(src_sel, 3'b000);
        on_low[0] <= 1'b1;
        cyc(3);
        chk_out(strobe_pin, 1'b1);
        cyc(BLANK + 2);
        chk_out(strobe_pin, 1'b0);
        chk_out(feedback_enable, 1'b1);
        chk_out(strobe_o, 1'b0);
        pol = polarity[0];
        on_low[0] <= 1'b0;
        cyc(3);
        chk_out(strobe_pin, 1'b1);
        chk_out(feedback_enable, 1'b0);
        chk_out(polarity[0], {31'h0, ~pol});
        on_low[0] <= 1'b1;
        inrush[0] <= 1'b1;
        cyc(BLANK + 4);
        chk_out(strobe_pin, 1'b1);
        chk_out(feedback_enable, 1'b0);
        inrush[0] <= 1'b0;
        cyc(BLANK + 4);
        chk_out(feedback_enable, 1'b1);
        fault[0] <= 1'b1;
        cyc(1);
        fault[0] <= 1'b0;
        cyc(3);
        chk_out(strobe_pin, 1'b1);
        channel_enabled[0] <= 1'b0;
        cyc(2);
        channel_enabled[0] <= 1'b1;
        cyc(BLANK + 4);
        chk_out(strobe_pin, 1'b0);
        set_ctrl(2'b00, 3'b000, 5'b00001);
        cyc(BLANK + 4);
        chk_out(strobe_pin, 1'b1);
        on_low[1] <= 1'b1;
        set_ctrl(2'b10, 3'b001, 5'b00000);
        cyc(BLANK + 6);
        chk_out(strobe_pin, 1'b1);
        cycle_start();
        cyc(4);
        chk_out(strobe_pin, 1'b0);
        full_duty[1] <= 1'b1;
        cycle_start();
        cyc(40);
        cycle_start();
        cyc(40);
        chk_out(high_len, OVF);
        chk_out(strobe_pin, 1'b0);
        full_duty[1] <= 1'b0;
        on_low[1] <= 1'b0;
        set_ctrl(2'b11, 3'b001, 5'b00000);
        cyc(BLANK + 2);
        repeat (3) begin
            len = 30 + ($random(seed) & 31);
            mid_pulse(len, 1'b0);
            mid_pulse(len, 1'b1);
        end
        set_ctrl(2'b01, 3'b000, 5'b00000);
        pwm_clock_failed <= 1'b1;
        cyc(100);
        chk_out(low_len, FAILH);
        chk_out(high_len, FAILH);
        pwm_clock_failed <= 1'b0;
        pwm_clk_tick <= 1'b1;
        set_ctrl(2'b01, 3'b101, 5'b00000);
        cyc(2200);
        chk_out(low_len, 512);
        chk_out(high_len, 512);
        pwm_clock_failed <= 1'b1;
        set_ctrl(2'b01, 3'b110, 5'b00001);
        cyc(100);
        chk_out(low_len, FAILH);
        chk_out(high_len, FAILH);
        for (int m = 1; m < 3; m++) begin
            device_mode <= 2'(m);
            cyc(3);
            bad = 1'b0;
            repeat (40) begin
                @(posedge mclk);
                if (strobe_pin !== 1'b1) bad = 1'b1;
            end
            chk_out(bad, 1'b0);
            chk_out(pm_mode, 5'b00000);
        end
        device_mode <= 2'b00;
        cyc(5);
        chk_out(pair_count != 32'h0, 1'b1);
        final_report();
    end
endmodule
